// ==== pkg/daw_pkg.sv ====
// Constants and command codes for the activate-window command front end
// Behaviour
// (RULE_01) Controller issues at most four ACTIVATEs in any 30 ns window.
// (RULE_02) Controller issues 8192 refreshes per 64ms, or per 32ms above 85C.
// (RULE_03) Bursts are eight beats by default; mode set may select chop four.
// (RULE_04) On-the-fly mode lets each READ or WRITE pick four or eight beats.
// (RULE_05) Eight banks: 3-bit bank, 15-bit row and 10-bit column fields.
// (RULE_06) 938ps clock: read latency, activate-to-column, precharge all 14.
// (RULE_07) Divide by average clock period; round minimums up, maximums down.
// (RULE_08) Device accepts commands spaced by the rounded-up clock count.
// (RULE_09) Controller tracks last four ACTIVATE times before issuing another.
package daw_pkg;
  // Link clock period and timing limits in picoseconds; read latency in clocks
  localparam int CK_PS = 938;
  localparam int FAW_PS = 30000;
  localparam int RCD_PS = 13090;
  localparam int RP_PS = 13090;
  localparam int READ_LATENCY = 14;
  // Minimum limits round up to whole link clocks
  localparam int FAW_NCK_I = (FAW_PS + CK_PS - 1) / CK_PS;
  localparam int RCD_NCK_I = (RCD_PS + CK_PS - 1) / CK_PS;
  localparam int RP_NCK_I = (RP_PS + CK_PS - 1) / CK_PS;
  localparam logic [5:0] FAW_NCK = 6'(FAW_NCK_I);
  localparam logic [5:0] RCD_NCK = 6'(RCD_NCK_I);
  localparam logic [5:0] RP_NCK = 6'(RP_NCK_I);
  localparam logic [5:0] AGE_MAX = 6'h3f;
  localparam logic [5:0] AGE_START = 6'h01;
  // Address split
  localparam int BANK_W = 3;
  localparam int ROW_W = 15;
  localparam int COL_W = 10;
  localparam int NUM_BANKS = 8;
  localparam int A10_POS = 10;
  localparam int A12_POS = 12;
  // Command pins {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PIN_MRS = 4'h0;
  localparam logic [3:0] PIN_REF = 4'h1;
  localparam logic [3:0] PIN_PRE = 4'h2;
  localparam logic [3:0] PIN_ACT = 4'h3;
  localparam logic [3:0] PIN_WR = 4'h4;
  localparam logic [3:0] PIN_RD = 4'h5;
  // Burst field of mode register 0
  localparam logic [1:0] MR_BL8 = 2'h0;
  localparam logic [1:0] MR_OTF = 2'h1;
  localparam logic [1:0] MR_BC4 = 2'h2;
  localparam logic [1:0] MR_RESET = 2'h0;
  localparam logic [3:0] BEATS_EIGHT = 4'h8;
  localparam logic [3:0] BEATS_FOUR = 4'h4;
  // Buffer geometry and word layout
  localparam int FIFO_AW = 5;
  localparam int WORD_W = 24;
  localparam int WF_KIND = 21;
  localparam int WF_BANK = 18;
  localparam int WF_FAW = 2;
  localparam int WF_RCD = 1;
  localparam int WF_RP = 0;
  typedef enum logic [2:0] {
    DAW_K_MRS, DAW_K_REF, DAW_K_PRE, DAW_K_ACT, DAW_K_WR, DAW_K_RD
  } daw_kind_e;
endpackage

// ==== rtl/daw_async_fifo.sv ====
// Dual-clock FIFO with gray-coded pointers
`timescale 1ns/10ps
module daw_async_fifo #(
  parameter int W = 24,
  parameter int AW = 5
) (
  input wire logic wr_clk,
  input wire logic wr_rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [2**AW];
  logic [AW:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
  logic [AW:0] rq1_reg, rq2_reg, wq1_reg, wq2_reg;
  logic [AW:0] wbin_next, rbin_next;

  // Full when write pointer leads read pointer by the whole depth
  assign wr_ready = wgray_reg !=
    {~rq2_reg[AW:AW-1], rq2_reg[AW-2:0]};
  assign rd_valid = rgray_reg != wq2_reg;
  assign rd_data = mem[rbin_reg[AW-1:0]];
  assign wbin_next = wbin_reg + (AW+1)'(wr_valid && wr_ready);
  assign rbin_next = rbin_reg + (AW+1)'(rd_valid && rd_ready);

  // Storage write
  always_ff @(posedge wr_clk) begin
    if (wr_valid && wr_ready) begin
      mem[wbin_reg[AW-1:0]] <= wr_data;
    end
  end

  // Write pointer and read pointer synchroniser
  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wbin_reg <= '0;
      wgray_reg <= '0;
      rq1_reg <= '0;
      rq2_reg <= '0;
    end else begin
      wbin_reg <= wbin_next;
      wgray_reg <= wbin_next ^ (wbin_next >> 1);
      rq1_reg <= rgray_reg;
      rq2_reg <= rq1_reg;
    end
  end

  // Read pointer and write pointer synchroniser
  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin_reg <= '0;
      rgray_reg <= '0;
      wq1_reg <= '0;
      wq2_reg <= '0;
    end else begin
      rbin_reg <= rbin_next;
      rgray_reg <= rbin_next ^ (rbin_next >> 1);
      wq1_reg <= wgray_reg;
      wq2_reg <= wq1_reg;
    end
  end
endmodule // daw_async_fifo

// ==== rtl/daw_cmd_front.sv ====
// Command front end: link-side decode and timing checks, system-side events
`timescale 1ns/10ps
module daw_cmd_front (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic LINK_CK,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [2:0] BA,
  input wire logic [14:0] A,
  output logic LINK_ACCEPT,
  input wire logic EV_READY,
  output logic EV_VALID,
  output logic [2:0] EV_KIND,
  output logic [2:0] EV_BANK,
  output logic [14:0] EV_ROW,
  output logic [9:0] EV_COL,
  output logic [3:0] EV_BEATS,
  output logic [1:0] BURST_MODE,
  output logic FAW_VIOL,
  output logic RCD_VIOL,
  output logic RP_VIOL,
  output logic BUF_OVERFLOW
);
  localparam int NB = daw_pkg::NUM_BANKS;

  logic lrst_q1_reg, lrst_q2_reg;
  logic srst_q1_reg, srst_q2_reg;
  logic [3:0] pins;
  logic cmd_known, is_act, is_pre, is_col, pre_all;
  logic [2:0] kind;
  logic [5:0] faw_age_reg [4];
  logic [5:0] act_age_reg [NB];
  logic [5:0] pre_age_reg [NB];
  logic faw_err, rcd_err, rp_err;
  logic [daw_pkg::WORD_W-1:0] push_word;
  logic push_ready;
  logic ovf_link_reg, ovf_q1_reg, ovf_q2_reg;
  logic pop_valid, pop_ready;
  logic [daw_pkg::WORD_W-1:0] pop_word;
  logic [2:0] pop_kind;
  logic [14:0] pop_addr;
  logic [1:0] mode_reg;
  logic [3:0] beats;

  // Link reset: asserts at once, releases on the link clock
  always_ff @(posedge LINK_CK or negedge RESET_N) begin
    if (!RESET_N) begin
      lrst_q1_reg <= 1'b0;
      lrst_q2_reg <= 1'b0;
    end else begin
      lrst_q1_reg <= 1'b1;
      lrst_q2_reg <= lrst_q2_reg | lrst_q1_reg;
    end
  end

  // System reset: asserts at once, releases cleanly on the system clock
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      srst_q1_reg <= 1'b0;
      srst_q2_reg <= 1'b0;
    end else begin
      srst_q1_reg <= 1'b1;
      srst_q2_reg <= srst_q1_reg;
    end
  end

  // Command decode; pins are synchronous to the link clock
  always_comb begin
    pins = {CS_N, RAS_N, CAS_N, WE_N};
    cmd_known = 1'b1;
    kind = 3'(daw_pkg::DAW_K_MRS);
    case (pins)
      daw_pkg::PIN_MRS: kind = 3'(daw_pkg::DAW_K_MRS);
      daw_pkg::PIN_REF: kind = 3'(daw_pkg::DAW_K_REF);
      daw_pkg::PIN_PRE: kind = 3'(daw_pkg::DAW_K_PRE);
      daw_pkg::PIN_ACT: kind = 3'(daw_pkg::DAW_K_ACT);
      daw_pkg::PIN_WR: kind = 3'(daw_pkg::DAW_K_WR);
      daw_pkg::PIN_RD: kind = 3'(daw_pkg::DAW_K_RD);
      default: cmd_known = 1'b0;
    endcase
  end
  assign is_act = cmd_known && pins == daw_pkg::PIN_ACT;
  assign is_pre = cmd_known && pins == daw_pkg::PIN_PRE;
  assign is_col = cmd_known &&
    (pins == daw_pkg::PIN_RD || pins == daw_pkg::PIN_WR);
  assign pre_all = A[daw_pkg::A10_POS];

  // Spacing checks against rounded-up clock counts
  assign faw_err = is_act && faw_age_reg[3] < daw_pkg::FAW_NCK; // RULE_01
  assign rcd_err = is_col && act_age_reg[BA] < daw_pkg::RCD_NCK; // RULE_08
  assign rp_err = is_act && pre_age_reg[BA] < daw_pkg::RP_NCK; // RULE_08
  assign push_word = {kind, BA, A, faw_err, rcd_err, rp_err};

  // Ages of the four most recent activates, youngest first
  always_ff @(posedge LINK_CK or negedge lrst_q2_reg) begin
    if (!lrst_q2_reg) begin
      for (int i = 0; i < 4; i++) begin
        faw_age_reg[i] <= daw_pkg::AGE_MAX;
      end
    end else if (is_act) begin
      // New activate enters slot 0; older ones shift down one slot
      faw_age_reg[0] <= daw_pkg::AGE_START; // RULE_01
      for (int i = 1; i < 4; i++) begin
        faw_age_reg[i] <= faw_age_reg[i-1] +
          6'(faw_age_reg[i-1] != daw_pkg::AGE_MAX);
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (faw_age_reg[i] != daw_pkg::AGE_MAX) begin
          faw_age_reg[i] <= faw_age_reg[i] + 6'h01;
        end
      end
    end
  end

  // Per-bank ages since the last activate and the last precharge
  for (genvar b = 0; b < NB; b++) begin : g_bank
    always_ff @(posedge LINK_CK or negedge lrst_q2_reg) begin
      if (!lrst_q2_reg) begin
        act_age_reg[b] <= daw_pkg::AGE_MAX;
        pre_age_reg[b] <= daw_pkg::AGE_MAX;
      end else begin
        if (is_act && BA == 3'(b)) begin
          act_age_reg[b] <= daw_pkg::AGE_START;
        end else if (act_age_reg[b] != daw_pkg::AGE_MAX) begin
          act_age_reg[b] <= act_age_reg[b] + 6'h01;
        end
        if (is_pre && (pre_all || BA == 3'(b))) begin
          pre_age_reg[b] <= daw_pkg::AGE_START;
        end else if (pre_age_reg[b] != daw_pkg::AGE_MAX) begin
          pre_age_reg[b] <= pre_age_reg[b] + 6'h01;
        end
      end
    end
  end

  // Buffer state seen by the link, and sticky drop flag
  always_ff @(posedge LINK_CK or negedge lrst_q2_reg) begin
    if (!lrst_q2_reg) begin
      LINK_ACCEPT <= 1'b0;
      ovf_link_reg <= 1'b0;
    end else begin
      LINK_ACCEPT <= push_ready;
      ovf_link_reg <= ovf_link_reg | (cmd_known && !push_ready);
    end
  end

  daw_async_fifo #(.W(daw_pkg::WORD_W), .AW(daw_pkg::FIFO_AW)) u_fifo (
    .wr_clk(LINK_CK),
    .wr_rst_n(lrst_q2_reg),
    .wr_valid(cmd_known),
    .wr_ready(push_ready),
    .wr_data(push_word),
    .rd_clk(SYS_CLK),
    .rd_rst_n(srst_q2_reg),
    .rd_valid(pop_valid),
    .rd_ready(pop_ready),
    .rd_data(pop_word)
  );

  // System side: take a word when the event stage is empty or drained
  assign pop_ready = !EV_VALID || EV_READY;
  assign pop_kind = pop_word[daw_pkg::WF_KIND +: 3];
  assign pop_addr = pop_word[daw_pkg::WF_BANK-1 -: 15];

  // Burst length: fixed eight, fixed chop four, or per command
  always_comb begin
    case (mode_reg)
      daw_pkg::MR_BC4: beats = daw_pkg::BEATS_FOUR; // RULE_03
      daw_pkg::MR_OTF: beats = pop_addr[daw_pkg::A12_POS] ? // RULE_04
        daw_pkg::BEATS_EIGHT : daw_pkg::BEATS_FOUR;
      default: beats = daw_pkg::BEATS_EIGHT; // RULE_03
    endcase
  end

  // Mode register 0 burst field, written by mode set to bank 0
  always_ff @(posedge SYS_CLK or negedge srst_q2_reg) begin
    if (!srst_q2_reg) begin
      mode_reg <= daw_pkg::MR_RESET;
    end else if (pop_valid && pop_ready &&
      pop_kind == 3'(daw_pkg::DAW_K_MRS) &&
      pop_word[daw_pkg::WF_BANK +: 3] == 3'h0) begin
      mode_reg <= pop_addr[1:0]; // RULE_03
    end
  end

  // Event output stage
  always_ff @(posedge SYS_CLK or negedge srst_q2_reg) begin
    if (!srst_q2_reg) begin
      EV_VALID <= 1'b0;
      EV_KIND <= 3'h0;
      EV_BANK <= 3'h0;
      EV_ROW <= 15'h0000;
      EV_COL <= 10'h000;
      EV_BEATS <= 4'h0;
    end else if (pop_ready) begin
      EV_VALID <= pop_valid;
      if (pop_valid) begin
        EV_KIND <= pop_kind;
        EV_BANK <= pop_word[daw_pkg::WF_BANK +: 3]; // RULE_05
        EV_ROW <= pop_addr; // RULE_05
        EV_COL <= pop_addr[9:0]; // RULE_05
        EV_BEATS <= (pop_kind == 3'(daw_pkg::DAW_K_RD) ||
          pop_kind == 3'(daw_pkg::DAW_K_WR)) ? beats : 4'h0;
      end
    end
  end

  // Sticky status and overflow level crossing
  always_ff @(posedge SYS_CLK or negedge srst_q2_reg) begin
    if (!srst_q2_reg) begin
      BURST_MODE <= daw_pkg::MR_RESET;
      FAW_VIOL <= 1'b0;
      RCD_VIOL <= 1'b0;
      RP_VIOL <= 1'b0;
      ovf_q1_reg <= 1'b0;
      ovf_q2_reg <= 1'b0;
      BUF_OVERFLOW <= 1'b0;
    end else begin
      BURST_MODE <= mode_reg;
      if (pop_valid && pop_ready) begin
        FAW_VIOL <= FAW_VIOL | pop_word[daw_pkg::WF_FAW];
        RCD_VIOL <= RCD_VIOL | pop_word[daw_pkg::WF_RCD];
        RP_VIOL <= RP_VIOL | pop_word[daw_pkg::WF_RP];
      end
      ovf_q1_reg <= ovf_link_reg;
      ovf_q2_reg <= ovf_q1_reg;
      BUF_OVERFLOW <= ovf_q2_reg;
    end
  end

  // Checks
  sequence s_col_taken;
    pop_valid && pop_ready && (pop_kind == 3'(daw_pkg::DAW_K_RD) ||
      pop_kind == 3'(daw_pkg::DAW_K_WR));
  endsequence

  chk_fixed_eight: assert property ( // RULE_03
    @(posedge SYS_CLK) disable iff (!RESET_N)
    s_col_taken and mode_reg == daw_pkg::MR_BL8 |=> EV_BEATS == 4'h8)
    else $error("Fixed burst not eight beats");
  chk_fixed_chop: assert property ( // RULE_03
    @(posedge SYS_CLK) disable iff (!RESET_N)
    s_col_taken and mode_reg == daw_pkg::MR_BC4 |=> EV_BEATS == 4'h4)
    else $error("Chop mode not four beats");
  chk_otf_select: assert property ( // RULE_04
    @(posedge SYS_CLK) disable iff (!RESET_N)
    s_col_taken and mode_reg == daw_pkg::MR_OTF |=>
      EV_BEATS == ($past(pop_addr[12]) ? 4'h8 : 4'h4))
    else $error("Per-command burst choice ignored");
  chk_addr_split: assert property ( // RULE_05
    @(posedge SYS_CLK) disable iff (!RESET_N)
    s_col_taken |=> EV_VALID && EV_COL == $past(pop_addr[9:0]) &&
      EV_BANK == $past(pop_word[20:18]))
    else $error("Column or bank field misplaced");
  chk_rcd_spaced: assert property ( // RULE_08
    @(posedge LINK_CK) disable iff (!lrst_q2_reg)
    is_col ##0 act_age_reg[BA] >= daw_pkg::RCD_NCK |-> !push_word[1])
    else $error("Properly spaced column command flagged");
  chk_faw_fifth: assert property ( // RULE_01
    @(posedge LINK_CK) disable iff (!lrst_q2_reg)
    is_act ##1 is_act ##1 is_act ##1 is_act ##1 is_act |-> push_word[2])
    else $error("Five back to back activates not flagged");
endmodule // daw_cmd_front

// ==== dv/daw_ctrl_model.sv ====
// Memory controller model driving the command pins on the link clock
`timescale 1ns/10ps
module daw_ctrl_model (
  input wire logic link_ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [14:0] a
);
  // Deselected at start
  initial begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n, ba, a} = '0;
  end
  // One command held for one link cycle, launched after a rising edge
  task automatic send(input logic [3:0] pins, input logic [2:0] b,
                      input logic [14:0] ad);
    @(posedge link_ck);
    {cs_n, ras_n, cas_n, we_n} <= pins;
    ba <= b;
    a <= ad;
  endtask
  // Deselect; unselected lines flip so stale values never look valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge link_ck);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n, ba, a} <= ~{ras_n, cas_n, we_n, ba, a};
    end
  endtask
endmodule // daw_ctrl_model

// ==== dv/testbench.sv ====
// Self-checking bench for the command front end
`timescale 1ns/10ps
module testbench;
  typedef struct {
    logic [2:0] k;
    logic [2:0] b;
    logic [14:0] a;
    logic [3:0] bt;
    logic [2:0] fl;
  } daw_exp_s;
  localparam int CK = daw_pkg::CK_PS;
  localparam int FAW_N = (daw_pkg::FAW_PS + CK - 1) / CK;
  localparam int RCD_N = (daw_pkg::RCD_PS + CK - 1) / CK;
  localparam int RP_N = (daw_pkg::RP_PS + CK - 1) / CK;
  logic SYS_CLK = 1'b0;
  logic LINK_CK = 1'b0;
  logic RESET_N = 1'b0;
  logic EV_READY = 1'b0;
  logic CS_N, RAS_N, CAS_N, WE_N, LINK_ACCEPT, EV_VALID;
  logic FAW_VIOL, RCD_VIOL, RP_VIOL, BUF_OVERFLOW;
  logic [2:0] BA, EV_KIND, EV_BANK, flags;
  logic [14:0] A, EV_ROW;
  logic [9:0] EV_COL;
  logic [3:0] EV_BEATS;
  logic [1:0] BURST_MODE, mode;
  daw_exp_s expq[$];
  int miscompares = 0;
  int comparisons = 0;
  // System clock; link clock with its own phase
  always #12.5 SYS_CLK = ~SYS_CLK;
  initial begin
    #7;
    forever #16 LINK_CK = ~LINK_CK;
  end
  daw_cmd_front u_daw_cmd_front (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
    .LINK_CK(LINK_CK), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
    .WE_N(WE_N), .BA(BA), .A(A), .LINK_ACCEPT(LINK_ACCEPT),
    .EV_READY(EV_READY), .EV_VALID(EV_VALID), .EV_KIND(EV_KIND),
    .EV_BANK(EV_BANK), .EV_ROW(EV_ROW), .EV_COL(EV_COL),
    .EV_BEATS(EV_BEATS), .BURST_MODE(BURST_MODE), .FAW_VIOL(FAW_VIOL),
    .RCD_VIOL(RCD_VIOL), .RP_VIOL(RP_VIOL), .BUF_OVERFLOW(BUF_OVERFLOW));
  daw_ctrl_model u_daw_ctrl_model (.link_ck(LINK_CK), .cs_n(CS_N),
    .ras_n(RAS_N), .cas_n(CAS_N), .we_n(WE_N), .ba(BA), .a(A));
  // Counts a comparison; reports and counts a mismatch
  task automatic chk(input logic [14:0] seen, input logic [14:0] exp,
                     input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  // Sends a command and queues the event it should give
  task automatic cmd(input logic [3:0] pins, input logic [2:0] b,
                     input logic [14:0] ad, input logic [2:0] fl, int gap);
    daw_exp_s e;
    logic rw;
    rw = pins == daw_pkg::PIN_RD || pins == daw_pkg::PIN_WR;
    flags = flags | fl;
    e.k = pins[2:0];
    e.b = b;
    e.a = ad;
    e.fl = flags;
    e.bt = !rw ? 4'h0 : (mode == daw_pkg::MR_BC4 ||
      (mode == daw_pkg::MR_OTF && !ad[12])) ? 4'h4 : 4'h8;
    expq.push_back(e);
    u_daw_ctrl_model.send(pins, b, ad);
    if (gap > 1) u_daw_ctrl_model.idle(gap - 1);
  endtask
  // Waits for an event under a bound
  task automatic take(output bit got);
    int n;
    n = 0;
    @(negedge SYS_CLK);
    while (EV_VALID !== 1'b1 && n < 80) begin
      @(negedge SYS_CLK);
      n++;
    end
    got = EV_VALID === 1'b1;
  endtask
  // Takes the standing event with one ready cycle
  task automatic ack();
    @(posedge SYS_CLK);
    EV_READY <= 1'b1;
    @(posedge SYS_CLK);
    EV_READY <= 1'b0;
  endtask
  // Releases the pins, then judges every queued event in order
  task automatic drain();
    daw_exp_s e;
    bit got;
    u_daw_ctrl_model.idle(1);
    while (expq.size() > 0) begin
      e = expq.pop_front();
      take(got);
      chk(got, 1'b1, "event missing");
      chk(EV_KIND, e.k, "kind");
      chk(EV_BANK, e.b, "bank");
      chk(EV_ROW, e.a, "row");
      chk(EV_COL, e.a[9:0], "column");
      chk(EV_BEATS, e.bt, "beats");
      chk({FAW_VIOL, RCD_VIOL, RP_VIOL}, e.fl, "flags");
      ack();
    end
  endtask
  // Burst default, every burst mode, per-command choice
  task automatic t_burst();
    logic [1:0] modes [3];
    modes = '{daw_pkg::MR_OTF, daw_pkg::MR_BC4, daw_pkg::MR_BL8};
    chk(BURST_MODE, daw_pkg::MR_RESET, "burst default");
    cmd(daw_pkg::PIN_RD, 3'h7, 15'h6fff, 3'h0, 1);
    cmd(daw_pkg::PIN_REF, 3'h0, 15'h0000, 3'h0, 1);
    cmd(daw_pkg::PIN_PRE, 3'h2, 15'h0400, 3'h0, 1);
    drain();
    foreach (modes[i]) begin
      mode = modes[i];
      cmd(daw_pkg::PIN_MRS, 3'h0, {13'h0, mode}, 3'h0, 1);
      drain();
      repeat (4) @(negedge SYS_CLK);
      chk(BURST_MODE, mode, "burst field");
      cmd(daw_pkg::PIN_RD, 3'(i), 15'h1234, 3'h0, 1);
      cmd(daw_pkg::PIN_WR, 3'(i + 4), 15'h0abc, 3'h0, 1);
      drain();
    end
    $display("burst test done");
  endtask
  // Column and activate spacing at the limit and one clock short
  task automatic t_rcd_rp();
    cmd(daw_pkg::PIN_ACT, 3'h1, 15'h0111, 3'h0, RCD_N);
    cmd(daw_pkg::PIN_RD, 3'h1, 15'h0010, 3'h0, 1);
    cmd(daw_pkg::PIN_ACT, 3'h2, 15'h0222, 3'h0, RCD_N - 1);
    cmd(daw_pkg::PIN_WR, 3'h2, 15'h0020, 3'h2, 1);
    cmd(daw_pkg::PIN_PRE, 3'h3, 15'h0000, 3'h0, RP_N);
    cmd(daw_pkg::PIN_ACT, 3'h3, 15'h0333, 3'h0, 1);
    cmd(daw_pkg::PIN_PRE, 3'h0, 15'h0400, 3'h0, RP_N - 1);
    cmd(daw_pkg::PIN_ACT, 3'h4, 15'h0444, 3'h1, 1);
    drain();
    $display("spacing test done");
  endtask
  // Four-activate window exactly met four times, then one clock short
  task automatic t_faw();
    int gaps [9];
    gaps = '{1, 1, 1, FAW_N - 3, 1, 1, 1, FAW_N - 4, 1};
    u_daw_ctrl_model.idle(40);
    foreach (gaps[i])
      cmd(daw_pkg::PIN_ACT, 3'(i), 15'(i * 291),
        (i == 8) ? 3'h4 : 3'h0, gaps[i]);
    // Five activates on consecutive clocks: every one breaks the window
    repeat (5) cmd(daw_pkg::PIN_ACT, 3'h5, 15'h0555, 3'h4, 1);
    drain();
    $display("window test done");
  endtask
  // Consumer stalls until the buffer refuses, then empties it
  task automatic t_overflow();
    int cnt;
    bit got;
    cnt = 0;
    got = 1'b1;
    repeat (40) u_daw_ctrl_model.send(daw_pkg::PIN_REF, 3'h0, 15'h0000);
    u_daw_ctrl_model.idle(4);
    repeat (8) @(negedge SYS_CLK);
    chk(LINK_ACCEPT, 1'b0, "accept while full");
    chk(BUF_OVERFLOW, 1'b1, "overflow flag");
    while (got) begin
      take(got);
      if (got) begin
        cnt++;
        ack();
      end
    end
    chk(cnt >= 32 && cnt <= 33, 1'b1, "buffered count");
    u_daw_ctrl_model.idle(4);
    @(negedge LINK_CK);
    chk(LINK_ACCEPT, 1'b1, "accept after drain");
    $display("buffer test done");
  endtask
  // Prints the counts and the verdict, then ends the run
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    flags = 3'h0;
    mode = daw_pkg::MR_RESET;
    repeat (8) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    u_daw_ctrl_model.idle(70);
    t_burst();
    t_rcd_rp();
    t_faw();
    t_overflow();
    conclude();
  end
  // Watchdog against a hang
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule // testbench
